// >>> pcb_consts.svh
// crossbar constants: pin counts, signal ranks, select-field positions, resets
// assumes inclusion from the type package and the crossbar modules only
`ifndef PCB_CONSTS_SVH
`define PCB_CONSTS_SVH

// -----------------------------------------------------------------------------
// pin space
// -----------------------------------------------------------------------------
`define PCB_NPIN      39
`define PCB_NXB       32
`define PCB_NSIG      22
`define PCB_OWN_W     5
`define PCB_OWN_NONE  5'h1f
`define PCB_SYNC_W    3
`define PCB_RD_SETTLE 3'h4

// -----------------------------------------------------------------------------
// signal ids, in priority rank (lower id wins the lower free pin; the serial pair keeps its fixed pins)
// -----------------------------------------------------------------------------
`define PCB_SIG_SER_TX  5'h00
`define PCB_SIG_SER_RX  5'h01
`define PCB_SIG_SPI_CLK 5'h02
`define PCB_SIG_SPI_MI  5'h03
`define PCB_SIG_SPI_MO  5'h04
`define PCB_SIG_SPI_SEL 5'h05
`define PCB_SIG_SMB_DAT 5'h06
`define PCB_SIG_SMB_CLK 5'h07
`define PCB_SIG_CMP0    5'h08
`define PCB_SIG_CMP0A   5'h09
`define PCB_SIG_CMP1    5'h0a
`define PCB_SIG_CMP1A   5'h0b
`define PCB_SIG_SYSCLK  5'h0c
`define PCB_SIG_CAP0    5'h0d
`define PCB_SIG_EXTCNT  5'h13
`define PCB_SIG_TMR0    5'h14
`define PCB_SIG_TMR1    5'h15
`define PCB_NCAP        6

// -----------------------------------------------------------------------------
// select register a / b field positions
// -----------------------------------------------------------------------------
`define PCB_SA_SER     0
`define PCB_SA_SPI     1
`define PCB_SA_SMB     2
`define PCB_SA_SYSCLK  3
`define PCB_SA_CMP0    4
`define PCB_SA_CMP0A   5
`define PCB_SA_CMP1    6
`define PCB_SA_CMP1A   7
`define PCB_SB_CAP_LO  0
`define PCB_SB_CAP_HI  2
`define PCB_SB_EXTCNT  3
`define PCB_SB_TMR0    4
`define PCB_SB_TMR1    5
`define PCB_SB_XBAR    6
`define PCB_SB_PUD     7
`define PCB_SSM_3WIRE  2'h0

// -----------------------------------------------------------------------------
// fixed serial pins and reset values
// -----------------------------------------------------------------------------
`define PCB_TX_PIN_L   1
`define PCB_RX_PIN_L   2
`define PCB_TX_PIN_S   4
`define PCB_RX_PIN_S   5
`define PCB_IN_MODE_RST 39'h7f_ffff_ffff
`define PCB_SEL_RST     8'h00

`endif

// >>> pcb_pkg.sv
// crossbar types: configuration and peripheral carriers
// assumes pcb_consts.svh is on the include path
package pcb_pkg;
`include "pcb_consts.svh"

   // per-pin port configuration, one bit per pin (skip mask: routable pins only)
   typedef struct packed {
      logic [`PCB_NPIN-1:0] input_mode;   // 1 digital, 0 analog
      logic [`PCB_NPIN-1:0] output_mode;  // 1 push-pull, 0 open-drain
      logic [`PCB_NXB-1:0]  skip_mask;    // 1 skip pin for routing
      logic [`PCB_NPIN-1:0] data_latch;   // gpio output value
   } pcb_pin_cfg_t;

   // peripheral selection fields
   typedef struct packed {
      logic [7:0] sel_a;                  // periph_select_reg_a
      logic [7:0] sel_b;                  // periph_select_reg_b
      logic [1:0] ssm;                    // slave_select_mode_field
   } pcb_sel_t;

   // peripheral drive, indexed by signal id
   typedef struct packed {
      logic [`PCB_NSIG-1:0] val;
      logic [`PCB_NSIG-1:0] oe;
   } pcb_periph_drv_t;

   typedef logic [`PCB_OWN_W-1:0] pcb_owner_t;
endpackage

// >>> pcb_pin_sync.sv
// three-stage pin level synchroniser with agreement filter
// assumes asynchronous pin levels and a single system clock
`timescale 1ns/100ps
module pcb_pin_sync
   import pcb_pkg::*;
#(
   parameter int W = `PCB_NPIN
) (
   input  wire logic         clk_sys_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   // -----------------------------------------------------------------------------
   // sync chain
   // -----------------------------------------------------------------------------
   logic [W-1:0] s1_r;   // metastable stage, read only by s2
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;  // filtered level

   // chain shifts every edge
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lvl_r <= '0;
      end else begin
         lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
      end
   end

   assign level_o = lvl_r;
endmodule

// >>> pcb_crossbar.sv
// priority pin crossbar: routes peripherals onto free, unskipped port pins; the serial pair takes its fixed pins even when skipped
// assumes config ports driven from the system clock domain, pins asynchronous
//
// Functional notes
// [R1] signals ranked, first serial port highest
// [R2] each enabled signal takes lowest free pin
// [R3] serial lines on fixed pins per variant
// [R4] assigned pin passed over for next signal
// [R5] skipped pins treated as occupied
// [R6] skip bit n maps to pin n
// [R7] bus pairs and serial pairs claimed together
// [R8] leftover pins are contiguous gpio
// [R9] select line routed only in four-wire mode
// [R10] only ports zero to three are routable
// [R11] input mode bit one digital, zero analog
// [R12] input modes reset to digital
// [R13] analog pin: no pullup, driver, receiver
// [R14] driver type follows output mode bit
// [R15] management bus pins always open-drain
// [R16] pullup on open-drain unless disabled
// [R17] pullup off when driving low or analog
// [R18] disabled crossbar: plain inputs, selections ignored
// [R19] drivers off while crossbar disabled
// [R20] port read returns pin levels
// [R21] software orders configuration, enable last
// [R22] software skips pins used outside crossbar
// [R23] new routing applies next clock cycle
// [R24] routed pin from peripheral, else latch
`timescale 1ns/100ps
module pcb_crossbar
   import pcb_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1   // 1: largest pin-out variant
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 reset_i,
   input  wire pcb_pin_cfg_t         pin_cfg_i,
   input  wire pcb_sel_t             sel_i,
   input  wire pcb_periph_drv_t      periph_drv_i,
   input  wire logic [`PCB_NPIN-1:0] pin_level_i,
   output logic      [`PCB_NPIN-1:0] pin_out_o,
   output logic      [`PCB_NPIN-1:0] pin_oe_o,
   output logic      [`PCB_NPIN-1:0] pin_pullup_o,
   output logic      [`PCB_NPIN-1:0] port_read_o,
   output logic      [`PCB_NSIG-1:0] periph_in_o,
   output logic      [`PCB_NXB-1:0]  pin_routed_o
);
   // -----------------------------------------------------------------------------
   // fixed serial pin positions
   // -----------------------------------------------------------------------------
   localparam int TX_PIN = LARGE_PKG ? `PCB_TX_PIN_L : `PCB_TX_PIN_S;
   localparam int RX_PIN = LARGE_PKG ? `PCB_RX_PIN_L : `PCB_RX_PIN_S;

   // -----------------------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------------------
   // one-hot pin mask, used by routing and by checks
   function automatic logic [`PCB_NXB-1:0] pin_bit(input int p);
      logic [`PCB_NXB-1:0] m;
      m = '0;
      m[p] = 1'b1;
      return m;
   endfunction

   // priority walk: highest-ranked signal first, lowest free pin first
   function automatic logic [`PCB_NXB*`PCB_OWN_W-1:0] route(
      input logic [`PCB_NSIG-1:0] req,
      input logic [`PCB_NXB-1:0]  skip);
      logic [`PCB_NXB-1:0]          taken;
      logic [`PCB_NXB*`PCB_OWN_W-1:0] own;
      logic                         done;
      // all-ones owner code marks a free pin
      own   = '1;
      taken = skip;                                    // [R5] [R6]
      // serial pair is placed first, on its fixed pins
      if (req[`PCB_SIG_SER_TX]) begin                  // [R1] [R3] [R7]
         own[TX_PIN*`PCB_OWN_W +: `PCB_OWN_W] = `PCB_SIG_SER_TX;
         own[RX_PIN*`PCB_OWN_W +: `PCB_OWN_W] = `PCB_SIG_SER_RX;
         taken = taken | pin_bit(TX_PIN) | pin_bit(RX_PIN);
      end
      // rank order after the serial pair
      // done keeps one signal off a second pin
      for (int s = 2; s < `PCB_NSIG; s++) begin        // [R1]
         done = 1'b0;
         for (int p = 0; p < `PCB_NXB; p++) begin
            if (req[s] && !done && !taken[p]) begin    // [R2] [R4]
               own[p*`PCB_OWN_W +: `PCB_OWN_W] = `PCB_OWN_W'(s);
               taken[p] = 1'b1;
               done     = 1'b1;
            end
         end
      end
      return own;
   endfunction

   // -----------------------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------------------
   // one edge of latency buys a registered source
   pcb_pin_cfg_t cfg_r;   // captured pin configuration
   pcb_sel_t     sel_r;   // captured selections

   // capture on every edge; the one-cycle hop gives a clean reset state
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cfg_r.input_mode  <= `PCB_IN_MODE_RST;        // [R12]
         cfg_r.output_mode <= '0;
         cfg_r.skip_mask   <= '0;
         cfg_r.data_latch  <= '0;
      end else begin
         cfg_r <= pin_cfg_i;                           // [R23]
      end
   end

   // selections, enable and pullup disable
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sel_r.sel_a <= `PCB_SEL_RST;
         sel_r.sel_b <= `PCB_SEL_RST;
         sel_r.ssm   <= `PCB_SSM_3WIRE;
      end else begin
         sel_r <= sel_i;                               // [R23]
      end
   end

   // -----------------------------------------------------------------------------
   // request vector
   // -----------------------------------------------------------------------------
   logic                       xbar_en;   // crossbar enable bit
   logic                       pud;       // pullup disable bit
   logic                       four_wire; // spi needs its select line
   logic [`PCB_NSIG-1:0]       req;       // requested signals
   logic [`PCB_NXB*`PCB_OWN_W-1:0] own_flat;

   // enable and pullup disable sit in register b
   assign xbar_en   = sel_r.sel_b[`PCB_SB_XBAR];
   assign pud       = sel_r.sel_b[`PCB_SB_PUD];
   assign four_wire = sel_r.ssm != `PCB_SSM_3WIRE;

   // decode selections; nothing is requested while disabled
   always_comb begin
      req = '0;
      if (xbar_en) begin                               // [R18]
         req[`PCB_SIG_SER_TX]  = sel_r.sel_a[`PCB_SA_SER];   // [R7]
         req[`PCB_SIG_SER_RX]  = sel_r.sel_a[`PCB_SA_SER];
         req[`PCB_SIG_SPI_CLK] = sel_r.sel_a[`PCB_SA_SPI];
         req[`PCB_SIG_SPI_MI]  = sel_r.sel_a[`PCB_SA_SPI];
         req[`PCB_SIG_SPI_MO]  = sel_r.sel_a[`PCB_SA_SPI];
         // select line only in four-wire mode
         req[`PCB_SIG_SPI_SEL] = sel_r.sel_a[`PCB_SA_SPI] & four_wire;  // [R9]
         req[`PCB_SIG_SMB_DAT] = sel_r.sel_a[`PCB_SA_SMB];   // [R7]
         req[`PCB_SIG_SMB_CLK] = sel_r.sel_a[`PCB_SA_SMB];
         req[`PCB_SIG_CMP0]    = sel_r.sel_a[`PCB_SA_CMP0];
         req[`PCB_SIG_CMP0A]   = sel_r.sel_a[`PCB_SA_CMP0A];
         req[`PCB_SIG_CMP1]    = sel_r.sel_a[`PCB_SA_CMP1];
         req[`PCB_SIG_CMP1A]   = sel_r.sel_a[`PCB_SA_CMP1A];
         req[`PCB_SIG_SYSCLK]  = sel_r.sel_a[`PCB_SA_SYSCLK];
         // capture modules are taken as a count, lowest module first
         for (int k = 0; k < `PCB_NCAP; k++) begin
            req[int'(`PCB_SIG_CAP0) + k] =
               sel_r.sel_b[`PCB_SB_CAP_HI:`PCB_SB_CAP_LO] > 3'(k);
         end
         // counter and timer inputs rank last
         req[`PCB_SIG_EXTCNT]  = sel_r.sel_b[`PCB_SB_EXTCNT];
         req[`PCB_SIG_TMR0]    = sel_r.sel_b[`PCB_SB_TMR0];
         req[`PCB_SIG_TMR1]    = sel_r.sel_b[`PCB_SB_TMR1];
      end
   end

   // only the 32 pins of ports zero to three enter the walk
   assign own_flat = route(req, cfg_r.skip_mask);      // [R10]

   // -----------------------------------------------------------------------------
   // pin level input
   // -----------------------------------------------------------------------------
   logic [`PCB_NPIN-1:0] lvl;   // filtered pin levels

   pcb_pin_sync #(
      .W (`PCB_NPIN)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .pin_i     (pin_level_i),
      .level_o   (lvl)
   );

   // receiver off in analog mode, so those bits read zero
   assign port_read_o = lvl & cfg_r.input_mode;        // [R20] [R11] [R13]

   // -----------------------------------------------------------------------------
   // per-pin output cell
   // -----------------------------------------------------------------------------
   logic [`PCB_NXB-1:0] smb_mask;   // pins carrying the management bus
   logic [`PCB_NXB-1:0] sel_mask;   // pins carrying the spi select line

   // driver and pullup for every pin, route status for the pins of ports zero to three
   always_comb begin
      pcb_owner_t o;
      logic       v;
      logic       e;
      logic       pp;
      logic       drv;
      o            = `PCB_OWN_NONE;
      v            = 1'b0;
      e            = 1'b0;
      pp           = 1'b0;
      drv          = 1'b0;
      // every output set on every path
      pin_out_o    = '0;
      pin_oe_o     = '0;
      pin_pullup_o = '0;
      pin_routed_o = '0;
      smb_mask     = '0;
      sel_mask     = '0;
      periph_in_o  = '0;
      for (int p = 0; p < `PCB_NPIN; p++) begin
         o = `PCB_OWN_NONE;
         if (p < `PCB_NXB) begin                       // [R10]
            o = own_flat[p*`PCB_OWN_W +: `PCB_OWN_W];
         end
         pp = cfg_r.output_mode[p];                    // [R14]
         if (o != `PCB_OWN_NONE) begin
            // routed pin: value and enable from the peripheral
            v  = periph_drv_i.val[o];                  // [R24]
            e  = periph_drv_i.oe[o];
            pin_routed_o[p] = 1'b1;
            // filtered pad level, zero if analog
            periph_in_o[o]  = lvl[p] & cfg_r.input_mode[p];
            if (o == `PCB_SIG_SMB_DAT || o == `PCB_SIG_SMB_CLK) begin
               pp = 1'b0;                              // [R15]
               smb_mask[p] = 1'b1;
            end
            if (o == `PCB_SIG_SPI_SEL) begin
               sel_mask[p] = 1'b1;
            end
         end else begin
            // leftover pin is plain gpio from the latch
            v = cfg_r.data_latch[p];                   // [R8] [R24]
            e = 1'b1;
         end
         // disabled crossbar leaves every pad an input
         // open-drain only ever pulls low
         drv = xbar_en & cfg_r.input_mode[p] & e & (pp | ~v);  // [R19] [R13]
         pin_out_o[p] = v & pp;
         pin_oe_o[p]  = drv;
         // weak pullup: open-drain, digital, not disabled, not sinking
         pin_pullup_o[p] = cfg_r.input_mode[p] & ~pp & ~pud
                           & ~(drv & ~v);              // [R16] [R17] [R13]
      end
   end

   // -----------------------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------------------
   // helpers for the checks only
   logic [`PCB_NXB-1:0] uart_pins;  // fixed serial pair mask
   assign uart_pins = pin_bit(TX_PIN) | pin_bit(RX_PIN);

   logic [2:0]          rd_age_r;   // edges since reset, saturating

   // read check waits until the sync chain has refilled
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rd_age_r <= 3'h0;
      end else begin
         rd_age_r <= (rd_age_r == `PCB_RD_SETTLE) ? rd_age_r : rd_age_r + 3'h1;
      end
   end

   // enable sampled raw, outputs one edge later
   // reset cycles are disabled, so the hostile reset selections are not checked here
   AST_DRV_OFF_DISABLED: assert property (  // [R19]
      @(posedge clk_sys_i) disable iff (reset_i)
      !sel_i.sel_b[`PCB_SB_XBAR] |=> (pin_oe_o == '0) && (pin_routed_o == '0))
      else $error("driver on or pin routed while crossbar disabled");

   // analog pads quiet on all three paths
   // mode compared one edge late, like the capture
   AST_ANALOG_QUIET: assert property (  // [R13]
      @(posedge clk_sys_i) disable iff (reset_i)
      1'b1 |=> ((pin_oe_o | pin_pullup_o | port_read_o)
                & ~$past(pin_cfg_i.input_mode)) == '0)
      else $error("analog pin shows driver, pullup or receiver");

   // a sinking pad with pullup on wastes current
   AST_NO_PULLUP_LOW: assert property (  // [R17]
      @(posedge clk_sys_i) disable iff (reset_i)
      (pin_pullup_o & pin_oe_o & ~pin_out_o) == '0)
      else $error("pullup on while pin sinks low");

   // global disable beats every open-drain pad
   AST_PUD_KILLS_PULLUP: assert property (  // [R16]
      @(posedge clk_sys_i) disable iff (reset_i)
      sel_i.sel_b[`PCB_SB_PUD] |=> pin_pullup_o == '0)
      else $error("pullup on with pullup disable set");

   // fixed serial pins are exempt from skipping
   // a breach would land on an analog pin
   AST_SKIP_HONOURED: assert property (  // [R5]
      @(posedge clk_sys_i) disable iff (reset_i)
      1'b1 |=> (pin_routed_o & $past(pin_cfg_i.skip_mask) & ~uart_pins) == '0)
      else $error("peripheral routed onto skipped pin");

   // boot pins never move with other selections
   AST_SERIAL_FIXED: assert property (  // [R3]
      @(posedge clk_sys_i) disable iff (reset_i)
      sel_i.sel_b[`PCB_SB_XBAR] && sel_i.sel_a[`PCB_SA_SER]
      |=> own_flat[TX_PIN*`PCB_OWN_W +: `PCB_OWN_W] == `PCB_SIG_SER_TX
          && own_flat[RX_PIN*`PCB_OWN_W +: `PCB_OWN_W] == `PCB_SIG_SER_RX)
      else $error("serial pair not on its fixed pins");

   // three-wire spi leaves the select pin free
   AST_SELECT_BY_MODE: assert property (  // [R9]
      @(posedge clk_sys_i) disable iff (reset_i)
      sel_i.sel_b[`PCB_SB_XBAR] && sel_i.sel_a[`PCB_SA_SPI]
      && sel_i.ssm == `PCB_SSM_3WIRE |=> sel_mask == '0)
      else $error("select line routed in three-wire mode");

   // serial off, no skips: spi starts at pin zero
   // clock then miso on pins zero and one
   AST_LOWEST_PIN: assert property (  // [R2]
      @(posedge clk_sys_i) disable iff (reset_i)
      sel_i.sel_b[`PCB_SB_XBAR] && !sel_i.sel_a[`PCB_SA_SER]
      && sel_i.sel_a[`PCB_SA_SPI] && pin_cfg_i.skip_mask == '0
      |=> own_flat[0 +: `PCB_OWN_W] == `PCB_SIG_SPI_CLK
          && own_flat[`PCB_OWN_W +: `PCB_OWN_W] == `PCB_SIG_SPI_MI)
      else $error("highest ranked signal not on lowest free pin");

   // one bus pin alone is useless
   AST_BUS_PAIR: assert property (  // [R7]
      @(posedge clk_sys_i) disable iff (reset_i)
      sel_i.sel_b[`PCB_SB_XBAR] && sel_i.sel_a[`PCB_SA_SMB]
      && pin_cfg_i.skip_mask == '0 |=> $countones(smb_mask) == 2)
      else $error("management bus pair not claimed together");

   // a bus pad may only sink
   AST_BUS_OPEN_DRAIN: assert property (  // [R15]
      @(posedge clk_sys_i) disable iff (reset_i)
      (pin_oe_o[`PCB_NXB-1:0] & pin_out_o[`PCB_NXB-1:0] & smb_mask) == '0)
      else $error("management bus pin driven high");

   // filter lags the pad by up to four edges
   // only bits that held for two samples compared
   AST_READ_IS_PIN: assert property (  // [R20]
      @(posedge clk_sys_i) disable iff (reset_i)
      rd_age_r == `PCB_RD_SETTLE
      |-> ((port_read_o ^ ($past(pin_level_i, 3) & cfg_r.input_mode))
           & ~($past(pin_level_i, 3) ^ $past(pin_level_i, 4))) == '0)
      else $error("port read differs from settled pin level");
endmodule

// >>> pcb_pin_world.sv
// pad model: resolves each pad from device drive, outside driver and pullup
// assumes the bench sets the outside driver pattern between config steps
`timescale 1ns/100ps
module pcb_pin_world
   import pcb_pkg::*;
(
   input  wire logic                 clk_sys_i,
   input  wire logic [`PCB_NPIN-1:0] pin_out_i,
   input  wire logic [`PCB_NPIN-1:0] pin_oe_i,
   input  wire logic [`PCB_NPIN-1:0] pin_pullup_i,
   input  wire logic [`PCB_NPIN-1:0] ext_en_i,
   input  wire logic [`PCB_NPIN-1:0] ext_val_i,
   output logic      [`PCB_NPIN-1:0] pin_level_o,
   output logic      [`PCB_NPIN-1:0] steady_o
);
   // ----------------------------------------------------------------------
   // floating pads
   // ----------------------------------------------------------------------
   logic [`PCB_NPIN-1:0] float_r = '0;  // undriven pads wander each cycle

   // a floating pad never keeps its last value, so a stale read shows
   always_ff @(posedge clk_sys_i) begin
      float_r <= ~pin_level_o;
   end

   // device first, then outside driver, then pullup, else wander
   always_comb begin
      for (int p = 0; p < `PCB_NPIN; p++) begin
         if (pin_oe_i[p]) begin
            pin_level_o[p] = pin_out_i[p];
         end else if (ext_en_i[p]) begin
            pin_level_o[p] = ext_val_i[p];
         end else begin
            pin_level_o[p] = pin_pullup_i[p] | float_r[p];
         end
      end
      steady_o = pin_oe_i | ext_en_i | pin_pullup_i;  // level predictable
   end
endmodule

// >>> tb_priority_pin_crossbar.sv
// self-checking bench for the priority pin crossbar
// assumes pcb_pkg compiled first; pads resolved by pcb_pin_world
`timescale 1ns/100ps
module tb_priority_pin_crossbar;
   import pcb_pkg::*;
   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   logic            clk_sys_i = 1'b0;
   logic            reset_i = 1'b1;
   pcb_pin_cfg_t    cfg;
   pcb_sel_t        sel;
   pcb_periph_drv_t drv;
   logic [38:0]     lvl, stdy, ext_en, ext_val, p_out, p_oe, p_pu, p_rd;
   logic [38:0]     x_oe, x_out, x_pu;
   logic [21:0]     p_in;
   logic [31:0]     routed, x_rt;
   logic [4:0]      own [0:31];     // expected owner per routable pin
   logic [31:0]     lfsr = 32'h08f8d20d;
   int              fail_count = 0;
   int              samples_checked = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   pcb_crossbar #(.LARGE_PKG(1'b1)) dut_u (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_cfg_i(cfg), .sel_i(sel),
      .periph_drv_i(drv), .pin_level_i(lvl), .pin_out_o(p_out), .pin_oe_o(p_oe),
      .pin_pullup_o(p_pu), .port_read_o(p_rd), .periph_in_o(p_in), .pin_routed_o(routed));

   pcb_pin_world world_u (
      .clk_sys_i(clk_sys_i), .pin_out_i(p_out), .pin_oe_i(p_oe), .pin_pullup_i(p_pu),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(lvl), .steady_o(stdy));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
      return lfsr;
   endfunction

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // expected routing and pad drive from current cfg, sel and drv
   task automatic calc();
      logic [21:0] en;
      logic [31:0] tk;
      logic [4:0]  o;
      logic        pe, v, d;
      en = '0;
      en[1:0] = {2{sel.sel_a[0]}};
      en[4:2] = {3{sel.sel_a[1]}};
      en[5] = sel.sel_a[1] & (sel.ssm != 2'h0);
      en[7:6] = {2{sel.sel_a[2]}};
      en[11:8] = sel.sel_a[7:4];
      en[12] = sel.sel_a[3];
      for (int s = 0; s < 6; s++) en[13+s] = (s < sel.sel_b[2:0]);
      en[21:19] = sel.sel_b[5:3];
      if (!sel.sel_b[6]) en = '0;        // selections ignored when off
      tk = cfg.skip_mask;
      for (int p = 0; p < 32; p++) own[p] = 5'h1f;
      if (en[0]) begin                   // serial pair on fixed pins
         own[1] = 5'h00;
         own[2] = 5'h01;
         tk[2:1] = 2'h3;
      end
      for (int s = 2; s < 22; s++) begin
         for (int p = 0; en[s] && p < 32; p++) begin
            if (!tk[p]) begin
               own[p] = 5'(s);
               tk[p] = 1'b1;
               break;
            end
         end
      end
      for (int p = 0; p < 39; p++) begin
         o = (p < 32) ? own[p] : 5'h1f;
         pe = cfg.output_mode[p] & !(o == 5'h06 || o == 5'h07);
         v = (o != 5'h1f) ? drv.val[o] : cfg.data_latch[p];
         d = (o != 5'h1f) ? drv.oe[o] : 1'b1;
         x_oe[p] = sel.sel_b[6] & cfg.input_mode[p] & d & (pe | ~v);
         x_out[p] = v & pe;
         x_pu[p] = cfg.input_mode[p] & ~pe & ~sel.sel_b[7] & ~x_oe[p];
         if (p < 32) x_rt[p] = (o != 5'h1f);
      end
   endtask

   // modes, skips and selections first, enable last
   task automatic apply(input pcb_pin_cfg_t c, input pcb_sel_t s);
      pcb_sel_t s0;
      logic [21:0] xi, m;
      s0 = s;
      s0.sel_b[6] = 1'b0;
      @(negedge clk_sys_i);
      cfg = c;
      sel = s0;
      @(negedge clk_sys_i);
      chk("oe_off", p_oe, '0);
      sel = s;
      @(negedge clk_sys_i);
      calc();
      chk("routed", routed, x_rt);
      chk("oe", p_oe, x_oe);
      chk("out", p_out & x_oe, x_out & x_oe);
      chk("pullup", p_pu, x_pu);
      repeat (6) @(negedge clk_sys_i);
      xi = '0;
      m = '1;
      for (int p = 0; p < 32; p++) begin
         if (own[p] != 5'h1f) begin
            xi[own[p]] = lvl[p] & cfg.input_mode[p];
            m[own[p]] = stdy[p];
         end
      end
      chk("port_read", p_rd & stdy, lvl & cfg.input_mode & stdy);
      chk("periph_in", p_in & m, xi & m);
   endtask

   // random config; analog only on skipped or non-routable pins
   task automatic rand_cfg(output pcb_pin_cfg_t c, output pcb_sel_t s);
      logic [63:0] a, b;
      a = {rnd(), rnd()};
      c.skip_mask = a[31:0] & a[63:32];
      b = {rnd(), rnd()};
      c.input_mode = ~(b[38:0] & {7'h7f, c.skip_mask});
      a = {rnd(), rnd()};
      c.output_mode = a[38:0];
      c.data_latch = a[63:25];
      b = {rnd(), rnd()};
      s.sel_a = b[7:0];
      s.sel_b = {b[15:11], (b[10:8] == 3'h7) ? 3'h6 : b[10:8]};
      s.ssm = b[17:16];
      a = {rnd(), rnd()};
      drv.val = a[21:0];
      drv.oe = a[43:22];
      b = {rnd(), rnd()};
      ext_en = b[38:0] | a[63:25];
      ext_val = b[63:25];
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------------
   initial begin
      pcb_pin_cfg_t c;
      pcb_sel_t     s;
      cfg = '0;
      sel = '{sel_a: 8'hff, sel_b: 8'h7f, ssm: 2'h3};   // hostile during reset
      drv = '1;
      ext_en = '1;
      ext_val = '0;
      repeat (3) @(negedge clk_sys_i);
      chk("rst_oe", p_oe, '0);
      chk("rst_rt", routed, '0);
      chk("rst_pu", p_pu, {39{1'b1}});
      reset_i = 1'b0;
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin                  // every select mode
         rand_cfg(c, s);
         c = '0;
         c.input_mode = '1;
         s = '{sel_a: 8'h02, sel_b: 8'h40, ssm: 2'(i)};
         apply(c, s);
         chk("spi_pins", routed, (i == 0) ? 32'h7 : 32'hf);
      end
      $display("spi mode test done");
      rand_cfg(c, s);
      c.skip_mask = 32'h0000_0300;                       // port 1 pins 0,1 skipped
      c.input_mode[31:0] = c.input_mode[31:0] | ~c.skip_mask;
      s = '{sel_a: 8'hff, sel_b: 8'h7e, ssm: 2'h1};
      apply(c, s);
      c.skip_mask = '1;                                  // everything skipped
      apply(c, s);
      chk("serial_fixed", routed, 32'h6);
      s.sel_b = 8'hbe;                                   // disabled, pullups off
      apply(c, s);
      $display("skip and disable test done");
      for (int i = 0; i < 60; i++) begin
         rand_cfg(c, s);
         apply(c, s);
      end
      $display("random test done");
      report_and_stop();
   end

   initial begin
      #60000;
      fail_count++;
      report_and_stop();
   end
endmodule
